// >>> rtl/param_table_rom.sv
// Read-only discovery parameter table slice behind an APB slave
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// Operation
// (R1) Byte 0Bh returns 6Bh
// (R2) Byte 0Ch returns 08h
// (R3) Byte 0Dh returns 3Bh
// (R4) Byte 0Eh returns 88h
// (R5) Byte 0Fh returns BBh
// (R6) Byte 10h returns FEh
// (R7) Bytes 11h-15h, 18h, 19h return FFh
// (R8) Bytes 16h and 17h return FFh
// (R9) Byte 1Ah returns 48h
// (R10) Byte 1Bh returns EBh
// (R11) Bytes 1Ch, 1Dh return 0Ch, 20h
// (R12) Bytes 1Eh, 1Fh return 0Fh, 52h
// (R13) Bytes 20h, 21h return 10h, D8h
// (R14) Byte 22h 00h, byte 23h FFh
// (R15) Bytes 24h-27h form word FE_C1_5A_21
// (R16) Fourth-type time fields are all ones
// (R17) Third-type time: unit 01b, count 10000b
// (R18) Second-type time: unit 01b, count 01011b
// (R19) First-type time: unit 01b, count 00010b
// (R20) Low nibble 0001b, fourfold max multiplier
// (R21) Host maps unit codes to times
// (R22) Table content fixed, never written
// (R23) Successive reads ascend from given address
module param_table_rom
    import param_table_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire param_table_pkg::apb_req_t   apb_req,
    output      param_table_pkg::apb_rsp_t   apb_rsp
);
    import param_table_pkg::*;

    // ==========================================================
    // Table lookup
    // ==========================================================
    function automatic logic [7:0] tbl_byte(input logic [7:0] a);
        logic [31:0] et;
        et = ERASE_TIME;                      // R15 R16 R17 R18 R19 R20
        unique case (a)
            8'h0B:   tbl_byte = 8'h6B;                            // R1
            8'h0C:   tbl_byte = 8'h08;                            // R2
            8'h0D:   tbl_byte = 8'h3B;                            // R3
            8'h0E:   tbl_byte = 8'h88;                            // R4
            8'h0F:   tbl_byte = 8'hBB;                            // R5
            8'h10:   tbl_byte = 8'hFE;                            // R6
            8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
            8'h18, 8'h19:
                     tbl_byte = 8'hFF;                            // R7
            8'h16, 8'h17:
                     tbl_byte = 8'hFF;                            // R8
            8'h1A:   tbl_byte = 8'h48;                            // R9
            8'h1B:   tbl_byte = 8'hEB;                            // R10
            8'h1C:   tbl_byte = 8'h0C;                            // R11
            8'h1D:   tbl_byte = 8'h20;                            // R11
            8'h1E:   tbl_byte = 8'h0F;                            // R12
            8'h1F:   tbl_byte = 8'h52;                            // R12
            8'h20:   tbl_byte = 8'h10;                            // R13
            8'h21:   tbl_byte = 8'hD8;                            // R13
            8'h22:   tbl_byte = 8'h00;                            // R14
            8'h23:   tbl_byte = 8'hFF;                            // R14
            8'h24:   tbl_byte = et[7:0];                          // R15
            8'h25:   tbl_byte = et[15:8];                         // R15
            8'h26:   tbl_byte = et[23:16];                        // R15
            8'h27:   tbl_byte = et[31:24];                        // R15
            default: tbl_byte = OUT_OF_TABLE;
        endcase
    endfunction : tbl_byte

    // Four consecutive bytes, lowest address in the low lane
    function automatic logic [31:0] tbl_word(input logic [7:0] a);
        tbl_word = {tbl_byte(8'(a + 8'h03)), tbl_byte(8'(a + 8'h02)),
                    tbl_byte(8'(a + 8'h01)), tbl_byte(a)};
    endfunction : tbl_word

    function automatic logic in_table(input logic [7:0] a);
        in_table = (a >= TBL_FIRST) && (a <= TBL_LAST);
    endfunction : in_table

    // ==========================================================
    // State
    // ==========================================================
    logic [7:0]        ptr_r;
    logic [7:0]        ptr_nxt;
    logic              autoinc_r;
    logic              rej_r;
    logic              rej_nxt;
    logic              range_r;
    logic              range_nxt;
    logic              ready_r;

    // ==========================================================
    // Decode
    // ==========================================================
    wire        setup     = apb_req.psel && !apb_req.penable;
    wire        access    = apb_req.psel && apb_req.penable && ready_r;
    wire        wr        = access && apb_req.pwrite;
    wire        rd        = access && !apb_req.pwrite;
    wire [11:0] a         = apb_req.paddr;
    wire        hit_ctrl  = (a == OFS_CTRL);
    wire        hit_ptr   = (a == OFS_PTR);
    wire        hit_data  = (a == OFS_DATA);
    wire        hit_sts   = (a == OFS_STATUS);
    wire        hit_word  = (a == OFS_WORD0) || (a == OFS_WORD1)
                         || (a == OFS_WORD2) || (a == OFS_WORD3)
                         || (a == OFS_WORD4) || (a == OFS_WORD5)
                         || (a == OFS_WORD6);
    wire        mapped    = hit_ctrl || hit_ptr || hit_data
                         || hit_sts || hit_word;
    // Word windows start at table byte 0Bh and step by four bytes
    wire [11:0] word_off  = 12'(a - OFS_WORD0);
    wire [7:0]  word_base = 8'(TBL_FIRST + 8'(word_off));
    // Table space is read only; any write there is refused
    wire        tbl_wr    = wr && (hit_data || hit_word);       // R22
    wire        lo_lane   = apb_req.pstrb[0];

    // Pointer update: host sets the start, each data read moves up
    assign ptr_nxt =
        (wr && hit_ptr && lo_lane) ? apb_req.pwdata[7:0] :
        (rd && hit_data && autoinc_r) ? 8'(ptr_r + 8'h01) :    // R23
        ptr_r;

    // Sticky flags: a new event wins over a clear in the same cycle
    assign rej_nxt =
        tbl_wr ? 1'b1 :
        (wr && hit_sts && lo_lane && apb_req.pwdata[STS_REJ_B]) ? 1'b0 :
        rej_r;
    assign range_nxt =
        (rd && hit_data && !in_table(ptr_r)) ? 1'b1 :
        (wr && hit_sts && lo_lane && apb_req.pwdata[STS_RANGE_B]) ? 1'b0 :
        range_r;

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ptr_r     <= PTR_RST;
            autoinc_r <= AUTOINC_RST;
            rej_r     <= 1'b0;
            range_r   <= 1'b0;
        end
        else
        begin
            ptr_r   <= ptr_nxt;
            rej_r   <= rej_nxt;
            range_r <= range_nxt;
            if (wr && hit_ctrl && lo_lane)
                autoinc_r <= apb_req.pwdata[CTRL_AUTOINC_B];
        end
    end

    // No wait state: ready rises the cycle after setup
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ready_r  <= 1'b0;
        end
        else
        begin
            ready_r  <= setup;
        end
    end

    // pready/prdata/pslverr all come from flip-flops evaluated at setup
    logic [31:0] pre_rdata_r;
    logic        pre_err_r;
    wire         s_wr     = setup && apb_req.pwrite;
    wire         s_rd     = setup && !apb_req.pwrite;
    wire         s_tblwr  = s_wr && (hit_data || hit_word);     // R22
    wire [31:0]  s_rdata  =
        !s_rd     ? 32'h0000_0000 :
        hit_data  ? {24'h00_0000, tbl_byte(ptr_r)} :            // R23
        hit_word  ? tbl_word(word_base) :
        hit_ptr   ? {24'h00_0000, ptr_r} :
        hit_ctrl  ? {31'h0000_0000, autoinc_r} :
        hit_sts   ? {30'h0000_0000, range_r, rej_r} :
        32'h0000_0000;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pre_rdata_r <= 32'h0000_0000;
            pre_err_r   <= 1'b0;
        end
        else
        begin
            pre_rdata_r <= s_rdata;
            pre_err_r   <= setup && (!mapped || s_tblwr);
        end
    end

    // One driver for the whole answer bundle
    assign apb_rsp = '{pready:  ready_r,
                       prdata:  pre_rdata_r,
                       pslverr: pre_err_r};

endmodule : param_table_rom

// >>> common/param_table_pkg.sv
// Package: offsets, field layouts and contents of the parameter table slice
package param_table_pkg;

    // ==========================================================
    // Bus layout
    // ==========================================================
    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;

    // ==========================================================
    // Register byte addresses
    // ==========================================================
    localparam logic [11:0] OFS_CTRL       = 12'h000;
    localparam logic [11:0] OFS_PTR        = 12'h004;
    localparam logic [11:0] OFS_DATA       = 12'h008;
    localparam logic [11:0] OFS_WORD0      = 12'h010;
    localparam logic [11:0] OFS_WORD1      = 12'h014;
    localparam logic [11:0] OFS_WORD2      = 12'h018;
    localparam logic [11:0] OFS_WORD3      = 12'h01C;
    localparam logic [11:0] OFS_WORD4      = 12'h020;
    localparam logic [11:0] OFS_WORD5      = 12'h024;
    localparam logic [11:0] OFS_WORD6      = 12'h028;
    localparam logic [11:0] OFS_STATUS     = 12'h02C;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int          CTRL_AUTOINC_B = 0;
    localparam int          STS_REJ_B      = 0;
    localparam int          STS_RANGE_B    = 1;
    localparam logic [7:0]  PTR_RST        = 8'h0B;
    localparam logic        AUTOINC_RST    = 1'b1;

    // ==========================================================
    // Table span (relative byte addresses)
    // ==========================================================
    localparam logic [7:0]  TBL_FIRST      = 8'h0B;
    localparam logic [7:0]  TBL_LAST       = 8'h27;
    localparam logic [7:0]  OUT_OF_TABLE   = 8'hFF;

    // ==========================================================
    // Erase-time word fields
    // ==========================================================
    localparam logic [1:0]  UNIT_16MS      = 2'h1;
    localparam logic [1:0]  RES_UNIT       = 2'h3;
    localparam logic [4:0]  RES_COUNT      = 5'h1F;
    localparam logic [4:0]  T3_COUNT       = 5'h10;
    localparam logic [4:0]  T2_COUNT       = 5'h0B;
    localparam logic [4:0]  T1_COUNT       = 5'h02;
    localparam logic [3:0]  MAX_MULT       = 4'h1;

    typedef struct packed {
        logic [1:0] t4_unit;
        logic [4:0] t4_count;
        logic [1:0] t3_unit;
        logic [4:0] t3_count;
        logic [1:0] t2_unit;
        logic [4:0] t2_count;
        logic [1:0] t1_unit;
        logic [4:0] t1_count;
        logic [3:0] max_mult;
    } erase_time_t;

    localparam erase_time_t ERASE_TIME = '{
        t4_unit:  RES_UNIT,
        t4_count: RES_COUNT,
        t3_unit:  UNIT_16MS,
        t3_count: T3_COUNT,
        t2_unit:  UNIT_16MS,
        t2_count: T2_COUNT,
        t1_unit:  UNIT_16MS,
        t1_count: T1_COUNT,
        max_mult: MAX_MULT
    };

    // APB request bundle
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } apb_req_t;

    // APB answer bundle
    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } apb_rsp_t;

endpackage : param_table_pkg

// >>> verif/param_table_rom_props.sv
// Checker: APB timing and table words of the parameter table block
`timescale 1ns/10ps
module param_table_rom_props
    import param_table_pkg::*;
(
    input wire logic                      clk,
    input wire logic                      rst,
    input wire param_table_pkg::apb_req_t apb_req,
    input wire param_table_pkg::apb_rsp_t apb_rsp
);
    wire        setup_w = apb_req.psel && !apb_req.penable;
    wire        rd_w    = setup_w && !apb_req.pwrite;
    wire [11:0] a_w     = apb_req.paddr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Handshake
    // ==========================================================
    a_ready_after_setup: assert property (setup_w |=> apb_rsp.pready)
        else $error("pready missing after setup");
    a_ready_only_setup: assert property (!setup_w |=> !apb_rsp.pready)
        else $error("pready without setup");
    a_write_refused: assert property (setup_w && apb_req.pwrite &&
        a_w == OFS_WORD0 |=> apb_rsp.pready && apb_rsp.pslverr)
        else $error("table write not refused");

    // ==========================================================
    // Table words
    // ==========================================================
    a_word0_value: assert property (rd_w && a_w == OFS_WORD0
        |=> apb_rsp.prdata == 32'h883B_086B) else $error("word0 wrong");
    a_word1_value: assert property (rd_w && a_w == OFS_WORD1
        |=> apb_rsp.prdata == 32'hFFFF_FEBB) else $error("word1 wrong");
    a_word3_value: assert property (rd_w && a_w == OFS_WORD3
        |=> apb_rsp.prdata == 32'h48FF_FFFF) else $error("word3 wrong");
    a_word4_value: assert property (rd_w && a_w == OFS_WORD4
        |=> apb_rsp.prdata == 32'h0F20_0CEB) else $error("word4 wrong");
    a_word5_value: assert property (rd_w && a_w == OFS_WORD5
        |=> apb_rsp.prdata == 32'h00D8_1052) else $error("word5 wrong");
    a_word6_value: assert property (rd_w && a_w == OFS_WORD6
        |=> apb_rsp.prdata == 32'hC15A_21FF) else $error("word6 wrong");
endmodule : param_table_rom_props

bind param_table_rom param_table_rom_props chk_u (
    .clk     (clk),
    .rst     (rst),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp)
);

// >>> verif/host_apb_master.sv
// Host model: APB master and erase-time unit decoding
`timescale 1ns/10ps
module host_apb_master
    import param_table_pkg::*;
(
    input  wire logic                      clk,
    output      param_table_pkg::apb_req_t apb_req,
    input  wire param_table_pkg::apb_rsp_t apb_rsp
);
    initial apb_req = '0;

    // Unit codes 0..3 decode to 1 ms, 16 ms, 128 ms, 1 s
    function automatic int unit_ms(input logic [1:0] u);
        return (u == 2'h0) ? 1 : (u == 2'h1) ? 16 :
               (u == 2'h2) ? 128 : 1000;
    endfunction : unit_ms

    // Called just after an edge; request held until pready is sampled
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                     pwdata: d, pstrb: 4'hF};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do
            @(posedge clk);
        while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
    endtask : xfer

    task automatic idle;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : idle
endmodule : host_apb_master

// >>> verif/param_table_rom_tb.sv
// Testbench: table reads, refusals and pointer control over APB
`timescale 1ns/10ps
module param_table_rom_tb;
    import param_table_pkg::*;
    logic        clk;
    logic        rst;
    apb_req_t    apb_req;
    apb_rsp_t    apb_rsp;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [31:0] q;
    logic        e;
    logic [31:0] ew;
    localparam logic [7:0] TBL [0:28] = '{8'h6B, 8'h08, 8'h3B, 8'h88,
        8'hBB, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h48, 8'hEB, 8'h0C, 8'h20, 8'h0F, 8'h52, 8'h10,
        8'hD8, 8'h00, 8'hFF, 8'h21, 8'h5A, 8'hC1, 8'hFE};

    param_table_rom dut_u (.clk(clk), .rst(rst), .apb_req(apb_req),
                           .apb_rsp(apb_rsp));
    host_apb_master host_u (.clk(clk), .apb_req(apb_req),
                            .apb_rsp(apb_rsp));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [11:0] a);
        host_u.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q, e);
    endtask : wr

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            results();
        end
    end

    initial
    begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(OFS_CTRL);   check("ctrl", q, 32'h1);
        rd(OFS_PTR);    check("ptr", q, 32'h0B);
        rd(OFS_STATUS); check("status", q, 32'h0);
        $display("test reset_values done");
        for (int n = 0; n < 7; n++)
        begin
            rd(OFS_WORD0 + 12'(4 * n));
            check("word", q, {TBL[4*n+3], TBL[4*n+2], TBL[4*n+1],
                              TBL[4*n]});
        end
        $display("test words done");
        for (int i = 0; i < 29; i++)
        begin
            rd(OFS_DATA);
            check("data", q, {24'h0, TBL[i]});
            ew = {q[7:0], ew[31:8]};
        end
        check("etime", ew, 32'hFEC1_5A21);
        check("t3", 32'((ew[22:18] + 1) * host_u.unit_ms(ew[24:23])),
              32'h0000_0110);
        check("t2", 32'((ew[15:11] + 1) * host_u.unit_ms(ew[17:16])),
              32'h0000_00C0);
        check("t1", 32'((ew[8:4] + 1) * host_u.unit_ms(ew[10:9])),
              32'h0000_0030);
        rd(OFS_DATA);   check("past_end", q, 32'hFF);
        rd(OFS_STATUS); check("range", q, 32'h2);
        $display("test data_stream done");
        wr(OFS_WORD0, 32'h0); check("werr0", {31'h0, e}, 32'h1);
        wr(OFS_DATA, 32'h0);  check("werr1", {31'h0, e}, 32'h1);
        rd(OFS_STATUS); check("refused", q, 32'h3);
        wr(OFS_STATUS, 32'h3);
        rd(OFS_STATUS); check("cleared", q, 32'h0);
        rd(OFS_WORD0);  check("kept", q, 32'h883B_086B);
        rd(12'h100);    check("unmapped", {e, q[30:0]}, 32'h8000_0000);
        $display("test refusals done");
        wr(OFS_CTRL, 32'h0);
        wr(OFS_PTR, 32'h1C);
        rd(OFS_DATA);   check("hold0", q, 32'h0C);
        rd(OFS_DATA);   check("hold1", q, 32'h0C);
        rd(OFS_PTR);    check("ptr_kept", q, 32'h1C);
        host_u.idle();
        $display("test no_autoinc done");
        results();
    end
endmodule : param_table_rom_tb
